// >>> rtl/chic_pkg.sv
// shared constants of the card host interrupt block
package chic_pkg;

  // register byte addresses
  localparam logic [31:0] IRQ_ENABLE_ADDR = 32'hb000d064;
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'hb000d068;

  // reset values
  localparam logic [31:0] IRQ_ENABLE_RST  = 32'h00000000;
  localparam logic [31:0] IRQ_STATUS_RST  = 32'h00000000;

  // writable enables and write-one-to-clear flags share one layout
  localparam logic [31:0] IRQ_ENABLE_MASK = 32'h0003001f;
  localparam logic [31:0] IRQ_FLAG_MASK   = 32'h0003001f;

  // bit positions in the status register, the enable register uses only bits 0 to 4, 16 and 17
  localparam int TRANSFER_DONE_BIT    = 0;
  localparam int CARD_INT_BIT         = 1;
  localparam int CARD_INT_TIMEOUT_BIT = 2;
  localparam int READY_TIMEOUT_BIT    = 3;
  localparam int CHECKSUM_ERROR_BIT   = 4;
  localparam int INT_REG_LSB          = 8;
  localparam int INT_REG_MSB          = 11;
  localparam int PORT0_DETECT_BIT     = 16;
  localparam int PORT1_DETECT_BIT     = 17;
  localparam int PORT0_LEVEL_BIT      = 24;
  localparam int PORT1_LEVEL_BIT      = 25;

  // timing
  localparam int unsigned CLK_KHZ        = 10000;
  localparam int unsigned INT_TO_STD_MS  = 100;
  localparam int unsigned INT_TO_HC_MS   = 3500;
  localparam int unsigned INT_TO_STD_CYC = INT_TO_STD_MS * CLK_KHZ;
  localparam int unsigned INT_TO_HC_CYC  = INT_TO_HC_MS * CLK_KHZ;
  localparam int unsigned READY_TO_SCLK  = 16;
  localparam int          TIMER_W        = 26;
  localparam int          SYNC_SETTLE    = 3;

  // card interrupt wait sequence
  typedef enum logic [1:0]
  {
    CHIC_IDLE = 2'b00,
    CHIC_WAIT = 2'b01
  } chic_wait_t;

endpackage : chic_pkg

// >>> rtl/chic_timer_if.sv
// timer control bundle between the interrupt block and its timers
`timescale 1ns/1ps
interface chic_timer_if #(
  parameter int W = 26
);
  logic         arm;
  logic         tick;
  logic [W-1:0] limit;
  logic         expired;

  modport owner (output arm, output tick, output limit, input expired);
  modport timer (input arm, input tick, input limit, output expired);
endinterface : chic_timer_if

// >>> rtl/chic_timer.sv
// one-shot tick counter that pulses once when its limit is reached
`timescale 1ns/1ps
module chic_timer #(
  parameter int W = 26
)
(
  // clock and control
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic clkEn,
  // timer bundle
  chic_timer_if.timer tmr
);

  typedef struct packed {
    logic [W-1:0] count;
    logic         fired;
    logic         expired;
  } chic_tmr_state_t;

  chic_tmr_state_t st_q;
  chic_tmr_state_t st_d;
  logic [W-1:0]    countNx;

  assign countNx     = st_q.count + W'(1);
  assign tmr.expired = st_q.expired;

  always_comb
  begin
    st_d         = st_q;
    st_d.expired = 1'b0;
    if (!tmr.arm)
    begin
      // disarming restarts the wait from zero
      st_d.count = '0;
      st_d.fired = 1'b0;
    end
    else if (tmr.tick && !st_q.fired)
    begin
      st_d.count = countNx;
      if (countNx >= tmr.limit)
      begin
        st_d.fired   = 1'b1;
        st_d.expired = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      st_q <= '0;
    else if (clkEn)
      st_q <= st_d;
  end

endmodule : chic_timer

// >>> rtl/chic_sync.sv
// three-stage pin synchroniser with agreement filter and settle flag
`timescale 1ns/1ps
module chic_sync #(
  parameter int N = 3
)
(
  // clock and control
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         clkEn,
  // pins and clean levels
  input  wire logic [N-1:0] pins,
  output logic      [N-1:0] level,
  output logic              settled
);
  import chic_pkg::*;

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] level;
    logic [1:0]   age;
    logic         settled;
  } chic_sync_state_t;

  chic_sync_state_t st_q;
  chic_sync_state_t st_d;
  logic [N-1:0]     agree;

  assign agree   = ~(st_q.s2 ^ st_q.s3);
  assign level   = st_q.level;
  assign settled = st_q.settled;

  always_comb
  begin
    st_d       = st_q;
    st_d.s1    = pins;
    st_d.s2    = st_q.s1;
    st_d.s3    = st_q.s2;
    // a change counts only once stages two and three agree
    st_d.level = (agree & st_q.s2) | (~agree & st_q.level);
    if (st_q.age != 2'(SYNC_SETTLE))
      st_d.age = st_q.age + 2'd1;
    st_d.settled = (st_q.age == 2'(SYNC_SETTLE));
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      st_q <= '0;
    else if (clkEn)
      st_q <= st_d;
  end

endmodule : chic_sync

// >>> rtl/chic_irq_ctrl.sv
// interrupt enable and status block of the flash card host, wishbone slave
`timescale 1ns/1ps
module chic_irq_ctrl
  import chic_pkg::*;
#(
  parameter int unsigned INT_TO_STD_CYCLES = INT_TO_STD_CYC,
  parameter int unsigned INT_TO_HC_CYCLES  = INT_TO_HC_CYC
)
(
  // clock, reset, clock enable
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // wishbone slave
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [31:0] wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatW,
  output logic      [31:0] wbDatR,
  output logic             wbAck,
  // card pins
  input  wire logic        port0DetectPin,
  input  wire logic        port1DetectPin,
  input  wire logic        data0Pin,
  // packet engine events and modes
  input  wire logic        sclkTick,
  input  wire logic        handshakeActive,
  input  wire logic        transferDone,
  input  wire logic        readPacket,
  input  wire logic        crcCheck,
  input  wire logic [15:0] crcComputed,
  input  wire logic [15:0] crcReceived,
  input  wire logic        cardIntSeen,
  input  wire logic [3:0]  cardIntRegBits,
  input  wire logic        parallelMode,
  input  wire logic        highCapacity,
  // results
  output logic             irq,
  output logic             responseComplete
);

  typedef struct packed {
    logic [31:0] datR;
    logic        ack;
    logic [31:0] enable;
    logic [31:0] flags;
    logic [3:0]  intRegBits;
    logic [1:0]  detPrev;
    logic        detArmed;
    chic_wait_t  waitState;
    logic        irq;
    logic        respDone;
  } chic_state_t;

  chic_state_t st_q;
  chic_state_t st_d;

  // synchronised pins
  logic [2:0]  pinLevel;
  logic        pinSettled;
  logic        port0Level;
  logic        port1Level;
  logic        readyLevel;

  // bus decode
  logic        busReq;
  logic        hitEnable;
  logic        hitStatus;
  logic [31:0] byteMask;
  logic [31:0] clearMask;
  logic [31:0] setMask;
  logic [31:0] statusWord;

  chic_timer_if #(.W(TIMER_W)) intTmr ();
  chic_timer_if #(.W(TIMER_W)) rdyTmr ();

  chic_sync #(
    .N (3)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clkEn   (clkEn),
    .pins    ({data0Pin, port1DetectPin, port0DetectPin}),
    .level   (pinLevel),
    .settled (pinSettled)
  );

  assign port0Level = pinLevel[0];
  assign port1Level = pinLevel[1];
  assign readyLevel = pinLevel[2];

  // card int response wait, limit follows the card type
  assign intTmr.arm   = (st_q.waitState == CHIC_WAIT) && !cardIntSeen;
  assign intTmr.tick  = 1'b1;
  assign intTmr.limit = highCapacity ? TIMER_W'(INT_TO_HC_CYCLES)
                                     : TIMER_W'(INT_TO_STD_CYCLES);

  chic_timer #(
    .W (TIMER_W)
  ) u_int_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clkEn   (clkEn),
    .tmr     (intTmr)
  );

  // ready wait counts serial clocks while the handshake sees busy
  assign rdyTmr.arm   = handshakeActive && !readyLevel;
  assign rdyTmr.tick  = sclkTick;
  assign rdyTmr.limit = TIMER_W'(READY_TO_SCLK);

  chic_timer #(
    .W (TIMER_W)
  ) u_ready_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clkEn   (clkEn),
    .tmr     (rdyTmr)
  );

  assign busReq    = wbCyc && wbStb && !st_q.ack;
  assign hitEnable = (wbAdr == IRQ_ENABLE_ADDR);
  assign hitStatus = (wbAdr == IRQ_STATUS_ADDR);
  assign byteMask  = {{8{wbSel[3]}}, {8{wbSel[2]}},
                      {8{wbSel[1]}}, {8{wbSel[0]}}};

  // write one clears a flag, reserved and zero bits leave it
  assign clearMask = (busReq && wbWe && hitStatus)
                   ? (wbDatW & byteMask & IRQ_FLAG_MASK)
                   : 32'h00000000;

  // live view of the status register
  always_comb
  begin
    statusWord                          = '0;
    statusWord[4:0]                     = st_q.flags[4:0];
    statusWord[PORT0_DETECT_BIT]        = st_q.flags[PORT0_DETECT_BIT];
    statusWord[PORT1_DETECT_BIT]        = st_q.flags[PORT1_DETECT_BIT];
    statusWord[INT_REG_MSB:INT_REG_LSB] = st_q.intRegBits;
    statusWord[PORT0_LEVEL_BIT]         = port0Level;
    statusWord[PORT1_LEVEL_BIT]         = port1Level;
  end

  always_comb
  begin
    st_d          = st_q;
    st_d.respDone = 1'b0;
    setMask       = '0;

    // detect, done, checksum and ready timeout events set flags regardless of enables
    if (pinSettled)
    begin
      st_d.detPrev  = {port1Level, port0Level};
      st_d.detArmed = 1'b1;
      if (st_q.detArmed)
      begin
        // detect pins pass the synchroniser agreement filter, every filtered change after the settle flag and one arming cycle counts
        setMask[PORT0_DETECT_BIT] = port0Level ^ st_q.detPrev[0];
        setMask[PORT1_DETECT_BIT] = port1Level ^ st_q.detPrev[1];
      end
    end
    setMask[TRANSFER_DONE_BIT]  = transferDone;
    setMask[CHECKSUM_ERROR_BIT] = crcCheck && readPacket
                                && (crcComputed != crcReceived);
    setMask[READY_TIMEOUT_BIT]  = rdyTmr.expired;

    // card int wait after a transfer done seen in idle while the card int timeout enable is set
    case (st_q.waitState)
      CHIC_IDLE:
      begin
        if (transferDone)
        begin
          if (st_q.enable[CARD_INT_TIMEOUT_BIT])
            st_d.waitState = CHIC_WAIT;
          else
            st_d.respDone = 1'b1;
        end
      end
      CHIC_WAIT:
      begin
        if (cardIntSeen)
        begin
          setMask[CARD_INT_BIT] = 1'b1;
          if (parallelMode)
            st_d.intRegBits = cardIntRegBits;
          st_d.respDone  = 1'b1;
          st_d.waitState = CHIC_IDLE;
        end
        else if (intTmr.expired)
        begin
          setMask[CARD_INT_TIMEOUT_BIT] = 1'b1;
          st_d.respDone  = 1'b1;
          st_d.waitState = CHIC_IDLE;
        end
        else if (!st_q.enable[CARD_INT_TIMEOUT_BIT])
        begin
          // detection switched off mid-wait: give up quietly
          st_d.respDone  = 1'b1;
          st_d.waitState = CHIC_IDLE;
        end
      end
      default:
      begin
        st_d.waitState = CHIC_IDLE;
      end
    endcase

    // a new event wins over a clear in the same cycle
    st_d.flags = ((st_q.flags & ~clearMask) | setMask)
               & IRQ_FLAG_MASK;

    // one-cycle registered ack, unmapped reads return zero
    st_d.ack  = busReq;
    st_d.datR = '0;
    if (busReq)
    begin
      if (wbWe && hitEnable)
        st_d.enable = ((st_q.enable & ~byteMask) | (wbDatW & byteMask))
                    & IRQ_ENABLE_MASK;
      if (!wbWe && hitEnable)
        st_d.datR = st_q.enable;
      if (!wbWe && hitStatus)
        st_d.datR = statusWord;
    end

    // each flag gated by its own enable bit
    st_d.irq = |(st_q.flags & st_q.enable);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_q            <= '0;
      st_q.enable     <= IRQ_ENABLE_RST;
      st_q.flags      <= IRQ_STATUS_RST;
      st_q.waitState  <= CHIC_IDLE;
    end
    else if (clkEn)
    begin
      st_q <= st_d;
    end
  end

  assign wbDatR           = st_q.datR;
  assign wbAck            = st_q.ack;
  assign irq              = st_q.irq;
  assign responseComplete = st_q.respDone;

endmodule : chic_irq_ctrl

// >>> sim/chic_irq_ctrl_props.sv
// port checker of the card host interrupt block
`timescale 1ns/1ps
module chic_irq_props
  import chic_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // bus
  input wire logic        wbCyc,
  input wire logic        wbStb,
  input wire logic        wbWe,
  input wire logic [31:0] wbAdr,
  input wire logic [31:0] wbDatW,
  input wire logic [31:0] wbDatR,
  input wire logic        wbAck,
  // events
  input wire logic        transferDone,
  input wire logic        irq,
  input wire logic        responseComplete
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire         take = wbCyc && wbStb && !wbAck;
  logic [31:0] enQ;
  logic        rdEnQ;
  logic        rdStQ;
  // enable shadow, assumes full byte lanes on writes
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      enQ   <= 32'h0;
      rdEnQ <= 1'h0;
      rdStQ <= 1'h0;
    end
    else
    begin
      if (take && wbWe && wbAdr == IRQ_ENABLE_ADDR)
        enQ <= wbDatW & IRQ_ENABLE_MASK;
      rdEnQ <= take && !wbWe && wbAdr == IRQ_ENABLE_ADDR;
      rdStQ <= take && !wbWe && wbAdr == IRQ_STATUS_ADDR;
    end
  end
  a_ack_after_take: assert property (take |=> wbAck)
    else $error("no ack after request");
  a_ack_one_cycle: assert property (wbAck |=> !wbAck)
    else $error("ack longer than one cycle");
  a_idle_data_zero: assert property (!wbAck |-> wbDatR == 32'h0)
    else $error("read data without ack");
  a_enable_readback: assert property (rdEnQ |-> wbDatR == enQ)
    else $error("enable read differs");
  a_status_rsvd: assert property (rdStQ |-> (wbDatR & 32'hfcfcf0e0) == 0)
    else $error("reserved status bit set");
  a_irq_needs_enable: assert property ($past(enQ) == 0 |-> !irq)
    else $error("irq with all enables off");
  a_done_raises_irq: assert property (transferDone && enQ[0] |-> ##2 irq)
    else $error("done did not raise irq");
  a_direct_response: assert property (transferDone && !enQ[2]
    |=> responseComplete)
    else $error("no direct response");
  c_irq_up: cover property ($rose(irq));
  c_response: cover property (responseComplete);
  c_status_read: cover property (rdStQ);
endmodule : chic_irq_props
bind chic_irq_ctrl chic_irq_props chk_u
(
  .ref_clk, .rst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbDatW, .wbDatR, .wbAck,
  .transferDone, .irq, .responseComplete
);

// >>> sim/chic_card_model.sv
// card side: detect switches, ready line and card interrupt
`timescale 1ns/1ps
module chic_card_model
(
  // clock and bench commands
  input  wire logic       ref_clk,
  input  wire logic [1:0] cardIn,
  input  wire logic       busy,
  input  wire logic       intReq,
  input  wire logic [3:0] intCode,
  // pins and card interrupt
  output logic            port0DetectPin,
  output logic            port1DetectPin,
  output logic            data0Pin,
  output logic            cardIntSeen,
  output logic [3:0]      cardIntRegBits
);
  logic intReqQ = 1'h0;
  always_ff @(posedge ref_clk)
    intReqQ <= intReq;
  // register bits scrambled outside the interrupt pulse
  always_comb
  begin
    port0DetectPin = cardIn[0];
    port1DetectPin = cardIn[1];
    data0Pin       = !busy;
    cardIntSeen    = intReq && !intReqQ;
    cardIntRegBits = cardIntSeen ? intCode : ~intCode;
  end
endmodule : chic_card_model

// >>> sim/tb_card_host_irq_ctrl.sv
// bench of the card host interrupt block
`timescale 1ns/1ps
module tb_card_host_irq_ctrl
  import chic_pkg::*;
();
  localparam logic [31:0] ENA = IRQ_ENABLE_ADDR;
  localparam logic [31:0] STA = IRQ_STATUS_ADDR;
  logic        ref_clk, rst, clkEn, wbCyc, wbStb, wbWe, wbAck, irq;
  logic        port0DetectPin, port1DetectPin, data0Pin, sclkTick;
  logic        handshakeActive, transferDone, readPacket, crcCheck;
  logic        cardIntSeen, parallelMode, highCapacity, responseComplete;
  logic        busy, intReq, seen;
  logic [1:0]  cardIn;
  logic [3:0]  wbSel, cardIntRegBits, intCode;
  logic [15:0] crcComputed, crcReceived;
  logic [31:0] wbAdr, wbDatW, wbDatR;
  int          miscompares, checkCount;
  always #50 ref_clk = ~ref_clk;
  chic_irq_ctrl #(.INT_TO_STD_CYCLES(20), .INT_TO_HC_CYCLES(50)) dut_u
  (
    .ref_clk, .rst, .clkEn, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatW,
    .wbDatR, .wbAck, .port0DetectPin, .port1DetectPin, .data0Pin, .sclkTick,
    .handshakeActive, .transferDone, .readPacket, .crcCheck, .crcComputed,
    .crcReceived, .cardIntSeen, .cardIntRegBits, .parallelMode,
    .highCapacity, .irq, .responseComplete
  );
  chic_card_model card_u
  (
    .ref_clk, .cardIn, .busy, .intReq, .intCode, .port0DetectPin,
    .port1DetectPin, .data0Pin, .cardIntSeen, .cardIntRegBits
  );
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, exp);
    checkCount++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic we, input logic [31:0] adr, dat,
                      output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge ref_clk);
    wbCyc  <= 1'h1;
    wbStb  <= 1'h1;
    wbWe   <= we;
    wbAdr  <= adr;
    wbDatW <= dat;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wbAck !== 1'h1 && n < 16);
    rdat = wbDatR;
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
    if (n >= 16)
    begin
      miscompares++;
      end_of_test();
    end
  endtask : xfer
  task automatic wr(input logic [31:0] adr, dat);
    logic [31:0] d;
    xfer(1'h1, adr, dat, d);
  endtask : wr
  task automatic rd(input logic [31:0] adr, exp);
    logic [31:0] d;
    xfer(1'h0, adr, 32'h0, d);
    chk(d, exp);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic done;
    transferDone <= 1'h1;
    tick(1);
    transferDone <= 1'h0;
  endtask : done
  task automatic watch(input int n);
    seen = 1'h0;
    repeat (n)
    begin
      @(posedge ref_clk);
      seen = seen | responseComplete;
    end
  endtask : watch
  task automatic sclk(input int n);
    repeat (n)
    begin
      sclkTick <= 1'h1;
      tick(1);
      sclkTick <= 1'h0;
      tick(1);
    end
  endtask : sclk
  initial
  begin
    ref_clk = 1'h0;
    rst = 1'h1;
    clkEn = 1'h1;
    wbSel = 4'hf;
    {wbCyc, wbStb, wbWe, wbAdr, wbDatW, sclkTick, handshakeActive} = '0;
    {transferDone, readPacket, crcCheck, crcComputed, crcReceived} = '0;
    {parallelMode, highCapacity, cardIn, busy, intReq, intCode} = '0;
    miscompares = 0;
    checkCount = 0;
    tick(10);
    rst <= 1'h0;
    tick(8);
    rd(ENA, IRQ_ENABLE_RST);
    rd(STA, IRQ_STATUS_RST);
    wr(ENA, 32'hffffffff);
    rd(ENA, IRQ_ENABLE_MASK);
    wr(STA, 32'hffffffff);
    rd(STA, 32'h0);
    rd(32'hb000d0fc, 32'h0);
    $display("test registers end");
    wr(ENA, 32'h10);
    crcComputed <= 16'h1234;
    crcReceived <= 16'h1235;
    crcCheck <= 1'h1;
    done();
    crcCheck <= 1'h0;
    tick(3);
    chk(irq, 1'h0);
    rd(STA, 32'h1);
    readPacket <= 1'h1;
    crcCheck <= 1'h1;
    tick(1);
    crcCheck <= 1'h0;
    tick(3);
    chk(irq, 1'h1);
    rd(STA, 32'h11);
    wr(ENA, 32'h1);
    wr(STA, 32'h10);
    tick(2);
    chk(irq, 1'h1);
    wr(STA, 32'h0);
    rd(STA, 32'h1);
    wr(STA, 32'h1);
    tick(2);
    chk(irq, 1'h0);
    $display("test events end");
    wr(ENA, 32'h7);
    parallelMode <= 1'h1;
    intCode <= 4'ha;
    done();
    watch(6);
    chk(seen, 1'h0);
    intReq <= 1'h1;
    watch(4);
    chk(seen, 1'h1);
    rd(STA, 32'ha03);
    chk(irq, 1'h1);
    wr(STA, 32'h3);
    parallelMode <= 1'h0;
    intReq <= 1'h0;
    intCode <= 4'h5;
    done();
    tick(3);
    intReq <= 1'h1;
    tick(4);
    rd(STA, 32'ha03);
    wr(STA, 32'h3);
    wr(ENA, 32'h4);
    intReq <= 1'h0;
    done();
    watch(15);
    chk(seen, 1'h0);
    watch(12);
    chk(seen, 1'h1);
    rd(STA, 32'ha05);
    chk(irq, 1'h1);
    wr(STA, 32'h5);
    wr(ENA, 32'h8);
    busy <= 1'h1;
    handshakeActive <= 1'h1;
    tick(6);
    sclk(15);
    rd(STA, 32'ha00);
    sclk(1);
    tick(2);
    rd(STA, 32'ha08);
    chk(irq, 1'h1);
    busy <= 1'h0;
    handshakeActive <= 1'h0;
    wr(STA, 32'h8);
    $display("test card wait end");
    wr(ENA, 32'h10000);
    cardIn <= 2'h1;
    tick(8);
    rd(STA, 32'h1010a00);
    chk(irq, 1'h1);
    wr(STA, 32'h10000);
    cardIn <= 2'h3;
    tick(8);
    rd(STA, 32'h3020a00);
    chk(irq, 1'h0);
    wr(ENA, 32'h20000);
    tick(2);
    chk(irq, 1'h1);
    wr(STA, 32'h20000);
    rd(STA, 32'h3000a00);
    $display("test detect end");
    end_of_test();
  end
endmodule : tb_card_host_irq_ctrl
